/* File: rtl/ppr_pkg.sv */
package ppr_pkg;

    // Relative quantities in 0.1 % steps
    localparam int PCT_W        = 10;
    typedef logic [PCT_W-1:0] ppr_pct_t;
    localparam int       PCT_FULL   = 1000;
    localparam ppr_pct_t PCT_FULL_V = ppr_pct_t'(PCT_FULL);
    localparam ppr_pct_t SP_DEF     = 10'h1F4;

    // Gain in 0.1 steps, integral time in 10 ms, derivative time in 1 ms
    localparam int KP_W        = 14;
    localparam int TI_W        = 10;
    localparam int TD_W        = 14;
    localparam int KP_FULL     = 1000;
    localparam int KP_MAX      = 9999;
    localparam int TI_MAX      = 1000;
    localparam int TD_MAX      = 10000;
    localparam int TI_LSB_MS   = 10;
    localparam int TD_LSB_MS   = 1;
    localparam logic [KP_W-1:0] KP_DEF = 14'h00C8;
    localparam logic [TI_W-1:0] TI_DEF = 10'h0C8;
    localparam logic [TD_W-1:0] TD_DEF = 14'h0000;

    // Display range
    localparam int RANGE_W = 16;
    localparam logic [RANGE_W-1:0] RANGE_DEF = 16'h03E8;

    // Frequency in 0.01 Hz steps
    localparam int FREQ_W = 16;

    // Control beat timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int BEAT_TIME_MS    = 2;
    localparam int BEAT_CYCLES_DEF = BEAT_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // Scaling divisors of the integral and derivative terms
    localparam int I_DIV = PCT_FULL * TI_LSB_MS / BEAT_TIME_MS;
    localparam int D_DIV = BEAT_TIME_MS * PCT_FULL / TD_LSB_MS;

    // Target source codes
    localparam logic [2:0] TSRC_DIGITAL = 3'h0;
    localparam logic [2:0] TSRC_ANALOG  = 3'h1;
    localparam logic [2:0] TSRC_PULSE   = 3'h4;
    localparam logic [2:0] TSRC_COMM    = 3'h5;
    localparam logic [2:0] TSRC_MULTI   = 3'h6;
    localparam logic [2:0] TSRC_DEF     = 3'h0;

    // Feedback source codes
    localparam logic [3:0] FSRC_ANALOG  = 4'h0;
    localparam logic [3:0] FSRC_PULSE   = 4'h4;
    localparam logic [3:0] FSRC_COMM    = 4'h5;
    localparam logic [3:0] FSRC_MAX     = 4'h8;
    localparam logic [3:0] FSRC_DEF     = 4'h0;

    // Action direction
    localparam logic DIR_POS = 1'b0;
    localparam logic DIR_REV = 1'b1;

    typedef struct packed {
        ppr_pct_t            setpoint;
        logic [KP_W-1:0]     kp;
        logic [TI_W-1:0]     ti;
        logic [TD_W-1:0]     td;
        logic [RANGE_W-1:0]  range;
        logic [2:0]          tgt_src;
        logic [3:0]          fb_src;
        logic                dir;
    } ppr_cfg_s;

    localparam ppr_cfg_s CFG_DEF = '{
        setpoint: SP_DEF, kp: KP_DEF, ti: TI_DEF, td: TD_DEF,
        range: RANGE_DEF, tgt_src: TSRC_DEF, fb_src: FSRC_DEF,
        dir: DIR_POS};

    typedef struct packed {
        ppr_pct_t analog;
        ppr_pct_t pulse;
        ppr_pct_t comm;
        ppr_pct_t multistep;
    } ppr_src_s;

endpackage

/* File: rtl/ppr_display_scale.sv */
`timescale 1ns/10ps
module ppr_display_scale (
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    input  wire ppr_pkg::ppr_pct_t               value,
    input  wire logic [ppr_pkg::RANGE_W-1:0]     range,
    output logic      [ppr_pkg::RANGE_W-1:0]     disp_q
);
    import ppr_pkg::*;

    logic [RANGE_W-1:0] disp_d;
    logic [31:0]        prod;

    // R8 proportional display
    always_comb begin
        prod   = 32'(value) * 32'(range);
        disp_d = RANGE_W'(prod / 32'(PCT_FULL));
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            disp_q <= '0;
        end else begin
            disp_q <= disp_d;
        end
    end

    a_disp_bound: assert property (@(posedge mclk) disable iff (!nrst)
        value <= PCT_FULL_V |=> disp_q <= $past(range)) // R8
        else $error("display exceeds range");

endmodule

/* File: rtl/ppr_regulator.sv */
// Operation
// R1 - The target is the setpoint, analog, pulse, link or multi-step input.
// R2 - The stored target spans 0 to 100 percent and resets to 50 percent.
// R3 - Feedback is the analog, pulse or link input; other codes give zero.
// R4 - Feedback uses the target's 0 to 100 percent scale and is driven to it.
// R5 - Positive action with feedback below target drives the command up.
// R6 - Reverse action with feedback below target drives the command down.
// R7 - An active reverse terminal inverts the configured action direction.
// R8 - Display values scale so that 100 percent shows the configured range.
// R9 - Gain 100.0 at full deviation gives the maximum frequency.
// R10 - Full deviation held for the integral time adds the maximum frequency.
// R11 - The adjustment sums proportional, integral and derivative terms.
// R12 - A full change within the derivative time gives the maximum frequency.
// R13 - A new output is computed once every 2 ms control beat.
// R14 - Adjustment clamps at maximum frequency and halts integration.
`timescale 1ns/10ps
module ppr_regulator #(
    parameter int BEAT_CYCLES = ppr_pkg::BEAT_CYCLES_DEF
) (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          cfg_wr_en,
    input  wire ppr_pkg::ppr_cfg_s             cfg_wr,
    input  wire ppr_pkg::ppr_src_s             sources,
    input  wire logic                          rev_term_pin,
    input  wire logic [ppr_pkg::FREQ_W-1:0]    max_freq,
    output logic signed [ppr_pkg::FREQ_W:0]    freq_adj_q,
    output logic                               sat_q,
    output logic                               update_q,
    output logic                               cfg_reject_q,
    output logic [ppr_pkg::RANGE_W-1:0]        target_disp_q,
    output logic [ppr_pkg::RANGE_W-1:0]        feedback_disp_q
);
    import ppr_pkg::*;

    if (BEAT_CYCLES < 9) begin : g_bad_beat
        $error("BEAT_CYCLES must be at least 9");
    end
    // R4 full-scale clip
    function automatic ppr_pct_t clip(input ppr_pct_t v);
        clip = (v > PCT_FULL_V) ? PCT_FULL_V : v;
    endfunction

    // Configuration store
    ppr_cfg_s cfg_q, cfg_d;
    logic     cfg_reject_d;
    logic     cfg_ok;

    always_comb begin
        cfg_ok = (cfg_wr.setpoint <= PCT_FULL_V)
              && (cfg_wr.kp <= KP_W'(KP_MAX))
              && (cfg_wr.ti <= TI_W'(TI_MAX))
              && (cfg_wr.td <= TD_W'(TD_MAX))
              && (cfg_wr.fb_src <= FSRC_MAX);
        cfg_d        = cfg_q;
        cfg_reject_d = 1'b0;
        if (cfg_wr_en && cfg_ok) begin
            cfg_d = cfg_wr;
        end else if (cfg_wr_en) begin
            cfg_reject_d = 1'b1;
        end
    end

    // R2 setpoint default
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q        <= CFG_DEF;
            cfg_reject_q <= 1'b0;
        end else begin
            cfg_q        <= cfg_d;
            cfg_reject_q <= cfg_reject_d;
        end
    end

    // Reverse terminal synchroniser
    logic rev_meta_q;
    logic rev_sync_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rev_meta_q <= 1'b0;
            rev_sync_q <= 1'b0;
        end else begin
            rev_meta_q <= rev_term_pin;
            rev_sync_q <= rev_meta_q;
        end
    end

    // Source selection
    ppr_pct_t target_q, target_d;
    ppr_pct_t feedback_q, feedback_d;

    always_comb begin
        // R1 target source
        case (cfg_q.tgt_src)
            TSRC_DIGITAL: target_d = cfg_q.setpoint;
            TSRC_ANALOG:  target_d = clip(sources.analog);
            TSRC_PULSE:   target_d = clip(sources.pulse);
            TSRC_COMM:    target_d = clip(sources.comm);
            TSRC_MULTI:   target_d = clip(sources.multistep);
            default:      target_d = '0;
        endcase
        // R3 feedback source
        case (cfg_q.fb_src)
            FSRC_ANALOG:  feedback_d = clip(sources.analog);
            FSRC_PULSE:   feedback_d = clip(sources.pulse);
            FSRC_COMM:    feedback_d = clip(sources.comm);
            default:      feedback_d = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            target_q   <= '0;
            feedback_q <= '0;
        end else begin
            target_q   <= target_d;
            feedback_q <= feedback_d;
        end
    end

    // Control beat divider
    logic [31:0] beat_cnt_q, beat_cnt_d;
    logic        tick;

    // R13 beat divider
    always_comb begin
        tick       = (beat_cnt_q == 32'(BEAT_CYCLES - 1));
        beat_cnt_d = tick ? '0 : beat_cnt_q + 32'h1;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            beat_cnt_q <= '0;
        end else begin
            beat_cnt_q <= beat_cnt_d;
        end
    end

    // Regulator
    logic signed [11:0]     err_q, err_d, err_prev_q, err_prev_d;
    logic signed [31:0]     integ_q, integ_d;
    logic signed [FREQ_W:0] freq_adj_d;
    logic                   calc_q, sat_d, eff_rev;
    longint                 e_l, de_l, fm_l, lim_l, sum_l;
    longint                 p_l, i_l, d_l, tot_l;

    always_comb begin
        e_l   = longint'(err_q);
        de_l  = longint'(err_q) - longint'(err_prev_q);
        fm_l  = longint'(max_freq);
        lim_l = longint'(I_DIV) * longint'(cfg_q.ti);
        sum_l = longint'(integ_q);
        // R7 terminal override
        eff_rev = cfg_q.dir ^ rev_sync_q;
        // R5 R6 deviation sign
        if (eff_rev == DIR_REV) begin
            err_d = 12'(signed'({2'b00, feedback_q}))
                  - 12'(signed'({2'b00, target_q}));
        end else begin
            err_d = 12'(signed'({2'b00, target_q}))
                  - 12'(signed'({2'b00, feedback_q}));
        end
        err_prev_d = err_prev_q;
        if (!tick) begin
            err_d = err_q;
        end else begin
            err_prev_d = err_q;
        end
        // R14 integration halted while saturated
        if (calc_q && !sat_q) begin
            sum_l = sum_l + e_l;
            if (sum_l > lim_l) begin
                sum_l = lim_l;
            end else if (sum_l < -lim_l) begin
                sum_l = -lim_l;
            end
        end
        if (cfg_q.ti == '0) begin
            sum_l = 0;
        end
        integ_d = 32'(sum_l);
        // R9 proportional term
        p_l = longint'(cfg_q.kp) * e_l * fm_l
            / longint'(KP_FULL * PCT_FULL);
        // R10 integral term
        i_l = (cfg_q.ti == '0) ? 0 : sum_l * fm_l / lim_l;
        // R12 derivative term
        d_l = de_l * longint'(cfg_q.td) * fm_l / longint'(D_DIV);
        // R11 term sum
        tot_l = p_l + i_l + d_l;
        // R14 output saturation
        sat_d = 1'b0;
        if (tot_l >= fm_l) begin
            tot_l = fm_l;
            sat_d = 1'b1;
        end else if (tot_l <= -fm_l) begin
            tot_l = -fm_l;
            sat_d = 1'b1;
        end
        freq_adj_d = calc_q ? (FREQ_W+1)'(tot_l) : freq_adj_q;
        if (!calc_q) begin
            sat_d = sat_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            err_q      <= '0;
            err_prev_q <= '0;
            integ_q    <= '0;
            calc_q     <= 1'b0;
            update_q   <= 1'b0;
            freq_adj_q <= '0;
            sat_q      <= 1'b0;
        end else begin
            err_q      <= err_d;
            err_prev_q <= err_prev_d;
            integ_q    <= integ_d;
            calc_q     <= tick;
            update_q   <= calc_q;
            freq_adj_q <= freq_adj_d;
            sat_q      <= sat_d;
        end
    end

    // R8 display scaling
    ppr_display_scale u_tgt_disp (
        .mclk   (mclk),
        .nrst   (nrst),
        .value  (target_q),
        .range  (cfg_q.range),
        .disp_q (target_disp_q)
    );

    ppr_display_scale u_fb_disp (
        .mclk   (mclk),
        .nrst   (nrst),
        .value  (feedback_q),
        .range  (cfg_q.range),
        .disp_q (feedback_disp_q)
    );

    // Checks
    logic [31:0] since_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            since_q <= '0;
        end else begin
            since_q <= update_q ? 32'h1 : since_q + 32'(since_q != 32'h0);
        end
    end

    sequence s_calc_then_update;
        calc_q ##1 update_q;
    endsequence

    a_beat_pipeline: assert property (@(posedge mclk) disable iff (!nrst)
        tick |=> s_calc_then_update ##1 !update_q[*8]) // R13
        else $error("beat pipeline out of order");
    a_beat_spacing: assert property (@(posedge mclk) disable iff (!nrst)
        update_q && since_q != 32'h0 |-> since_q == 32'(BEAT_CYCLES)) // R13
        else $error("beat spacing wrong");
    a_digital_range: assert property (@(posedge mclk) disable iff (!nrst)
        cfg_q.setpoint <= PCT_FULL_V) // R2
        else $error("digital setpoint out of range");
    a_target_select: assert property (@(posedge mclk) disable iff (!nrst)
        cfg_q.tgt_src == TSRC_DIGITAL && !cfg_wr_en
        |=> target_q == cfg_q.setpoint) // R1
        else $error("digital target not selected");
    a_fb_reserved: assert property (@(posedge mclk) disable iff (!nrst)
        cfg_q.fb_src inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8}
        |=> feedback_q == '0) // R3
        else $error("reserved feedback code not zero");
    a_fb_scale: assert property (@(posedge mclk) disable iff (!nrst)
        feedback_q <= PCT_FULL_V && target_q <= PCT_FULL_V) // R4
        else $error("relative value above full scale");
    a_pos_action: assert property (@(posedge mclk) disable iff (!nrst)
        tick && !eff_rev && feedback_q < target_q |=> err_q > 0) // R5
        else $error("positive action sign wrong");
    a_rev_action: assert property (@(posedge mclk) disable iff (!nrst)
        tick && eff_rev && feedback_q < target_q |=> err_q < 0) // R6
        else $error("reverse action sign wrong");
    a_rev_override: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(rev_term_pin) ##2 !cfg_wr_en[*1] |->
        eff_rev == !cfg_q.dir) // R7
        else $error("reverse terminal ignored");
    a_full_gain: assert property (@(posedge mclk) disable iff (!nrst)
        calc_q && cfg_q.kp == KP_W'(KP_FULL) && cfg_q.ti == '0
        && cfg_q.td == '0 && err_q == 12'(PCT_FULL)
        |=> freq_adj_q == (FREQ_W+1)'($past(max_freq))) // R9
        else $error("full gain not max frequency");
    a_adj_limit: assert property (@(posedge mclk) disable iff (!nrst)
        update_q |-> freq_adj_q <= $signed({1'b0, $past(max_freq)})
        && freq_adj_q >= -$signed({1'b0, $past(max_freq)})) // R14
        else $error("adjustment exceeds max frequency");
    a_windup_hold: assert property (@(posedge mclk) disable iff (!nrst)
        calc_q && sat_q && cfg_q.ti != '0 && !cfg_wr_en
        |=> $stable(integ_q)) // R14
        else $error("integral moved while saturated");

endmodule

/* File: sim/ppr_sensor_model.sv */
`timescale 1ns/10ps
module ppr_sensor_model (
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    input  wire ppr_pkg::ppr_src_s               level,
    input  wire logic                            update_q,
    input  wire logic signed [ppr_pkg::FREQ_W:0] freq_adj_q,
    output ppr_pkg::ppr_src_s                    sources_q,
    output logic signed [ppr_pkg::FREQ_W+1:0]    freq_cmd_q
);
    import ppr_pkg::*;

    // Command that the adjustment is added to
    localparam logic signed [FREQ_W+1:0] BASE_FREQ = 18'h00FA0;

    ppr_src_s                 sources_d;
    logic signed [FREQ_W+1:0] freq_cmd_d;

    // Sensors sample once a clock; the command follows each new adjustment
    always_comb begin
        sources_d  = level;
        freq_cmd_d = freq_cmd_q;
        if (update_q) begin
            freq_cmd_d = BASE_FREQ + freq_adj_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sources_q  <= '0;
            freq_cmd_q <= '0;
        end else begin
            sources_q  <= sources_d;
            freq_cmd_q <= freq_cmd_d;
        end
    end
endmodule

/* File: sim/ppr_regulator_bench.sv */
`timescale 1ns/10ps
module ppr_regulator_bench;
    import ppr_pkg::*;
    localparam int BEAT = 20;
    logic                     mclk;
    logic                     nrst;
    logic                     cfg_wr_en;
    ppr_cfg_s                 cfg_wr;
    ppr_src_s                 lvl;
    ppr_src_s                 sources;
    logic                     rev_term_pin;
    logic [FREQ_W-1:0]        max_freq;
    logic signed [FREQ_W:0]   freq_adj_q;
    logic signed [FREQ_W+1:0] freq_cmd_q;
    logic                     sat_q;
    logic                     update_q;
    logic                     cfg_reject_q;
    logic [RANGE_W-1:0]       target_disp_q;
    logic [RANGE_W-1:0]       feedback_disp_q;
    int                       error_cnt = 0;
    int                       compares = 0;
    int                       n;
    ppr_cfg_s                 c;
    ppr_cfg_s                 b;
    int                       tsel[9] =
        '{500, 100, 0, 0, 200, 300, 400, 0, 500};
    int                       fsel[9] =
        '{100, 0, 0, 0, 200, 300, 0, 0, 0};

    ppr_regulator #(.BEAT_CYCLES(BEAT)) uut (
        .mclk(mclk), .nrst(nrst), .cfg_wr_en(cfg_wr_en), .cfg_wr(cfg_wr),
        .sources(sources), .rev_term_pin(rev_term_pin),
        .max_freq(max_freq), .freq_adj_q(freq_adj_q), .sat_q(sat_q),
        .update_q(update_q), .cfg_reject_q(cfg_reject_q),
        .target_disp_q(target_disp_q), .feedback_disp_q(feedback_disp_q));

    ppr_sensor_model sensor (
        .mclk(mclk), .nrst(nrst), .level(lvl), .update_q(update_q),
        .freq_adj_q(freq_adj_q), .sources_q(sources),
        .freq_cmd_q(freq_cmd_q));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize();
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t value %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask

    task automatic cfg_write(input ppr_cfg_s v, input logic rej);
        @(negedge mclk);
        cfg_wr = v;
        cfg_wr_en = 1'b1;
        @(negedge mclk);
        cfg_wr_en = 1'b0;
        chk_bit(cfg_reject_q, rej);
        @(negedge mclk);
    endtask

    // Waits for the next update pulse; n is the spacing in cycles
    task automatic wait_upd();
        n = 1;
        @(negedge mclk);
        while (update_q !== 1'b1 && n < 3 * BEAT) begin
            @(negedge mclk);
            n++;
        end
        if (update_q !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t no update", $time);
        end
    endtask

    task automatic chk_out(input int adj, input logic sat);
        wait_upd();
        wait_upd();
        chk_val(freq_adj_q, adj);
        chk_bit(sat_q, sat);
    endtask

    initial begin
        nrst = 1'b0;
        cfg_wr_en = 1'b0;
        cfg_wr = CFG_DEF;
        rev_term_pin = 1'b0;
        max_freq = 16'h1388;
        lvl = '{analog: 10'h064, pulse: 10'h0C8, comm: 10'h12C,
                multistep: 10'h190};
        repeat (2) @(negedge mclk);
        chk_val(target_disp_q, 0); // display in reset
        chk_bit(update_q, 1'b0); // no beat in reset
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        chk_val(target_disp_q, 500); // default target
        chk_val(feedback_disp_q, 100); // feedback scale
        wait_upd();
        wait_upd();
        chk_val(n, BEAT); // beat spacing
        c = CFG_DEF;
        c.ti = 10'h000;
        for (int i = 0; i < 9; i++) begin
            c.tgt_src = 3'(i);
            c.fb_src = 4'(i);
            cfg_write(c, 1'b0);
            repeat (4) @(negedge mclk);
            chk_val(target_disp_q, tsel[i]); // target select
            chk_val(feedback_disp_q, fsel[i]); // feedback select
        end
        c = CFG_DEF;
        c.setpoint = 10'h14D;
        c.range = 16'hFFFF;
        cfg_write(c, 1'b0);
        repeat (4) @(negedge mclk);
        chk_val(target_disp_q, 21823); // display scale
        c.setpoint = 10'h3E8;
        c.range = 16'h07D0;
        cfg_write(c, 1'b0); // full target
        b = c;
        b.setpoint = 10'h3E9;
        cfg_write(b, 1'b1); // target limit
        b = c;
        b.kp = 14'h2710;
        cfg_write(b, 1'b1); // gain limit
        b = c;
        b.ti = 10'h3E9;
        cfg_write(b, 1'b1); // time limit
        b = c;
        b.td = 14'h2711;
        cfg_write(b, 1'b1); // time limit
        b = c;
        b.fb_src = 4'h9;
        cfg_write(b, 1'b1); // code limit
        repeat (4) @(negedge mclk);
        chk_val(target_disp_q, 2000); // write refused
        lvl.analog = 10'h0C8;
        c = CFG_DEF;
        c.setpoint = 10'h2BC;
        c.kp = 14'h01F4;
        c.ti = 10'h000;
        for (int i = 0; i < 4; i++) begin
            c.dir = i[0];
            rev_term_pin = i[1];
            cfg_write(c, 1'b0);
            chk_out((i[0] ^ i[1]) ? -1250 : 1250, 1'b0); // action
        end
        rev_term_pin = 1'b0;
        lvl.analog = 10'h000;
        c.dir = 1'b0;
        c.setpoint = 10'h3E8;
        c.kp = 14'h03E7;
        cfg_write(c, 1'b0);
        chk_out(4995, 1'b0); // proportional scale
        c.kp = 14'h03E8;
        cfg_write(c, 1'b0);
        chk_out(5000, 1'b1); // full gain
        c.kp = 14'h270F;
        c.dir = 1'b1;
        cfg_write(c, 1'b0);
        chk_out(-5000, 1'b1); // clamp
        c.kp = 14'h0000;
        c.dir = 1'b0;
        cfg_write(c, 1'b0);
        chk_out(0, 1'b0); // no terms
        c.ti = 10'h001;
        wait_upd();
        cfg_write(c, 1'b0); // integral on
        for (int k = 1; k < 7; k++) begin
            wait_upd();
            chk_val(freq_adj_q, (k < 5) ? 1000 * k : 5000); // ramp
            chk_bit(sat_q, k >= 5); // saturation
        end
        c.ti = 10'h000;
        c.td = 14'h0001;
        lvl.analog = 10'h3E8;
        cfg_write(c, 1'b0);
        chk_out(0, 1'b0); // no change
        lvl.analog = 10'h000;
        wait_upd();
        chk_val(freq_adj_q, 2500); // step response
        @(negedge mclk);
        chk_val(freq_cmd_q, 6500); // command adjusted
        wait_upd();
        chk_val(freq_adj_q, 0); // steady again
        summarize();
    end

    initial begin
        #200000;
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
